//--- hw/t16cc_timer.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "t16cc_defs.svh"

module t16cc_timer #(
   parameter int FILT_LEN = `T16CC_FILT_LEN // Capture filter length.
) (
   input  logic       clock,                   // System clock.
   input  logic       rst_n,                   // Async reset, low.
   input  logic [7:0] addr,                    // Register address.
   input  logic [7:0] wdata,                   // Write data.
   input  logic       wr_stb,                  // Write strobe.
   input  logic       rd_stb,                  // Read strobe.
   output logic [7:0] rdata,                   // Read data, next cycle.
   input  logic       capture_input_pin,       // Capture pin.
   input  logic       comparator_out,          // Comparator result.
   input  logic       capture_from_comparator, // Capture source pick.
   input  logic       external_count_pin,      // External count pin.
   input  logic       global_irq_en,           // Global enable.
   input  logic [3:0] vector_ack,              // Vector taken pulses.
   output logic [3:0] irq_req,                 // Interrupt requests.
   output logic       waveform_out_a,          // Channel A output.
   output logic       waveform_out_b,          // Channel B output.
   output logic       waveform_out_a_en,       // Channel A drives pin.
   output logic       waveform_out_b_en        // Channel B drives pin.
);

   logic [1:0]  com_r [2];
   logic [3:0]  wgm_r;
   logic        nf_r;
   logic        ces_r;
   logic [2:0]  cs_r;
   logic [3:0]  en_r;
   logic [3:0]  flg_r;
   logic [7:0]  temp_r;
   logic [15:0] cnt_r;
   logic [15:0] ocr_r [2];
   logic [15:0] icr_r;
   logic        up_r;
   logic        blk_r;
   logic [9:0]  pre_r;
   logic        ext_r;
   logic        ext_q_r;
   logic        wave_r [2];
   logic        cap_evt;

   // Prescaler tap test.
   function automatic logic tap(input logic [9:0] p,
                                input logic [9:0] m);
      tap = (p & m) == m;
   endfunction : tap

   // Top value for each waveform mode.
   function automatic logic [15:0] top_of(input logic [3:0]  m,
                                          input logic [15:0] oa,
                                          input logic [15:0] ic);
      case (m)
         4'h1, 4'h5:             top_of = `T16CC_TOP8;
         4'h2, 4'h6:             top_of = `T16CC_TOP9;
         4'h3, 4'h7:             top_of = `T16CC_TOP10;
         4'h4, 4'h9, 4'hb, 4'hf: top_of = oa;
         4'h8, 4'ha, 4'hc, 4'he: top_of = ic;
         default:                top_of = `T16CC_MAX;
      endcase
   endfunction : top_of

   // Next output level of one waveform channel.
   function automatic logic wave_nxt(input logic [1:0] com,
                                     input logic cur, input logic mt,
                                     input logic frc, input logic bot,
                                     input logic np, input logic dl,
                                     input logic up, input logic tg);
      wave_nxt = cur;
      if (np)
      begin
         if (mt || frc)
         begin
            case (com)
               t16cc_pkg::OUT_TOGGLE: wave_nxt = !cur;
               t16cc_pkg::OUT_CLEAR:  wave_nxt = 1'b0;
               t16cc_pkg::OUT_SET:    wave_nxt = 1'b1;
               default:               wave_nxt = cur;
            endcase
         end
      end
      else
      begin
         case (com)
            t16cc_pkg::OUT_TOGGLE: wave_nxt = (tg && mt) ? !cur : cur;
            t16cc_pkg::OUT_CLEAR:
               wave_nxt = dl ? (mt ? !up : cur) :
                          (bot ? 1'b1 : (mt ? 1'b0 : cur));
            t16cc_pkg::OUT_SET:
               wave_nxt = dl ? (mt ? up : cur) :
                          (bot ? 1'b0 : (mt ? 1'b1 : cur));
            default: wave_nxt = cur;
         endcase
      end
   endfunction : wave_nxt

   // Address decode.
   wire wr_a  = wr_stb && addr == `T16CC_CTRL_A;
   wire wr_b  = wr_stb && addr == `T16CC_CTRL_B;
   wire wr_c  = wr_stb && addr == `T16CC_CTRL_C;
   wire wr_f  = wr_stb && addr == `T16CC_FLAGS;
   wire wr_m  = wr_stb && addr == `T16CC_MASK;
   wire [7:0] wide_base = `T16CC_WIDE_BASE;
   wire wide  = addr[7:3] == wide_base[7:3];
   wire [1:0] idx = addr[2:1];
   wire wr_lo = wr_stb && wide && !addr[0];
   wire wr_hi = wr_stb && wide && addr[0];
   wire rd_lo = rd_stb && wide && !addr[0];
   wire wr_cnt = wr_lo && idx == 2'd0;
   wire [15:0] wr_val = {temp_r, wdata};

   // Wide register view, indexed by pair.
   wire [15:0] wide_q [4];
   assign wide_q[0] = cnt_r;
   assign wide_q[1] = ocr_r[0];
   assign wide_q[2] = ocr_r[1];
   assign wide_q[3] = icr_r;

   // Mode classes.
   wire [3:0] mode = wgm_r;
   wire nonpwm  = mode == 4'h0 || mode == 4'h4 ||
                  mode == 4'hc || mode == 4'hd;
   wire icr_top = mode == 4'h8 || mode == 4'ha ||
                  mode == 4'hc || mode == 4'he;
   wire dual    = (mode[3:2] == 2'b00 && mode[1:0] != 2'b00) ||
                  mode[3:2] == 2'b10;
   wire fast    = !nonpwm && !dual;
   wire [15:0] top = top_of(mode, ocr_r[0], icr_r);

   // Timer tick from prescaler taps or external edges.
   wire ext_rise = ext_r && !ext_q_r;
   wire ext_fall = !ext_r && ext_q_r;
   wire tick =
      (cs_r == t16cc_pkg::CLK_DIV1) ||
      (cs_r == t16cc_pkg::CLK_DIV8 && tap(pre_r, `T16CC_M8)) ||
      (cs_r == t16cc_pkg::CLK_DIV64 && tap(pre_r, `T16CC_M64)) ||
      (cs_r == t16cc_pkg::CLK_DIV256 && tap(pre_r, `T16CC_M256)) ||
      (cs_r == t16cc_pkg::CLK_DIV1024 && tap(pre_r, `T16CC_M1024)) ||
      (cs_r == t16cc_pkg::CLK_EXT_FALL && ext_fall) ||
      (cs_r == t16cc_pkg::CLK_EXT_RISE && ext_rise);

   // Counting sequence.
   wire at_top = cnt_r == top;
   wire at_bot = cnt_r == 16'h0000;
   wire up_nxt = at_top ? 1'b0 : (at_bot ? 1'b1 : up_r);
   wire [15:0] cnt_step =
      dual ? ((at_top && at_bot) ? 16'h0000 :
              (up_nxt ? cnt_r + 16'h0001 : cnt_r - 16'h0001)) :
      (at_top ? 16'h0000 : cnt_r + 16'h0001);

   // Compare matches and forced strobes.
   wire [1:0] hit;
   wire [1:0] force_stb = {wr_c && wdata[`T16CC_FOCB_BIT] && nonpwm,
                           wr_c && wdata[`T16CC_FOCA_BIT] && nonpwm};
   wire ov_set = tick && (nonpwm ? cnt_r == `T16CC_MAX :
                 (fast ? at_top : (at_bot && !up_r)));

   // Capture source and capture flag source.
   wire cap_src = capture_from_comparator ? comparator_out
                                          : capture_input_pin;
   wire cap_set = icr_top ? (tick && at_top) : cap_evt;

   // Flag update: a set in the clearing cycle wins.
   wire [3:0] flg_set = {cap_set, hit[1], hit[0], ov_set};
   wire [3:0] flg_clr = vector_ack | ({4{wr_f}} &
      {wdata[`T16CC_CAP_BIT], wdata[`T16CC_MB_BIT],
       wdata[`T16CC_MA_BIT], wdata[`T16CC_OV_BIT]});
   wire [3:0] flg_nxt = (flg_r & ~flg_clr) | flg_set;

   // Read selection; force bits and unmapped offsets read zero.
   wire [7:0] rd_mux =
      wide ? (addr[0] ? temp_r : wide_q[idx][7:0]) :
      addr == `T16CC_CTRL_A ? {com_r[0], com_r[1], 2'b00, wgm_r[1:0]} :
      addr == `T16CC_CTRL_B ? {nf_r, ces_r, 1'b0, wgm_r[3:2], cs_r} :
      addr == `T16CC_MASK   ? {en_r[3], 1'b0, en_r[2:0], 3'b000} :
      addr == `T16CC_FLAGS  ? {flg_r[3], 1'b0, flg_r[2:0], 3'b000} :
      8'h00;

   // Requests and pin drivers.
   assign irq_req = flg_r & en_r & {4{global_irq_en}};
   assign waveform_out_a    = wave_r[0];
   assign waveform_out_b    = wave_r[1];
   assign waveform_out_a_en = com_r[0] != 2'b00;
   assign waveform_out_b_en = com_r[1] != 2'b00;

   t16cc_capt_filter #(
      .LEN       (FILT_LEN)
   ) u_filt (
      .clock     (clock),
      .rst_n     (rst_n),
      .raw_in    (cap_src),
      .filter_en (nf_r),
      .edge_rise (ces_r),
      .enable    (!icr_top),
      .event_out (cap_evt)
   );

   // Control registers and mask.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wgm_r <= 4'h0;
         nf_r  <= 1'b0;
         ces_r <= 1'b0;
         cs_r  <= 3'h0;
         en_r  <= 4'h0;
      end
      else
      begin
         if (wr_a)
            wgm_r[1:0] <= wdata[1:0];
         if (wr_b)
         begin
            nf_r       <= wdata[`T16CC_NF_BIT];
            ces_r      <= wdata[`T16CC_CES_BIT];
            wgm_r[3:2] <= wdata[4:3];
            cs_r       <= wdata[2:0];
         end
         if (wr_m)
            en_r <= {wdata[7], wdata[5], wdata[4], wdata[3]};
      end
   end

   // Shared high-byte latch, read data and flags.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         temp_r <= `T16CC_RST8;
         rdata  <= `T16CC_RST8;
         flg_r  <= 4'h0;
      end
      else
      begin
         if (wr_hi)
            temp_r <= wdata;
         else if (rd_lo)
            temp_r <= wide_q[idx][15:8];
         rdata <= rd_stb ? rd_mux : 8'h00;
         flg_r <= flg_nxt;
      end
   end

   // Counter, direction, match block, prescaler and pin sample.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r   <= `T16CC_RST16;
         up_r    <= 1'b1;
         blk_r   <= 1'b0;
         pre_r   <= 10'h000;
         ext_r   <= 1'b0;
         ext_q_r <= 1'b0;
      end
      else
      begin
         if (wr_cnt)
            cnt_r <= wr_val;
         else if (tick)
            cnt_r <= cnt_step;
         if (!dual)
            up_r <= 1'b1;
         else if (tick && !wr_cnt)
            up_r <= up_nxt;
         if (wr_cnt)
            blk_r <= 1'b1;
         else if (tick)
            blk_r <= 1'b0;
         pre_r   <= pre_r + 10'h001;
         ext_r   <= external_count_pin;
         ext_q_r <= ext_r;
      end
   end

   // Capture register: a capture event wins over a write.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         icr_r <= `T16CC_RST16;
      else if (cap_evt)
         icr_r <= cnt_r;
      else if (wr_lo && idx == 2'd3)
         icr_r <= wr_val;
   end

   // Compare channels.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_ch
         assign hit[gi] = tick && !blk_r &&
                          cnt_r == ocr_r[gi];

         // Compare value, output mode and output level.
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ocr_r[gi]  <= `T16CC_RST16;
               com_r[gi]  <= 2'b00;
               wave_r[gi] <= 1'b0;
            end
            else
            begin
               if (wr_lo && idx == 2'(gi + 1))
                  ocr_r[gi] <= wr_val;
               if (wr_a)
                  com_r[gi] <= wdata[7 - 2 * gi -: 2];
               wave_r[gi] <= wave_nxt(com_r[gi], wave_r[gi],
                  hit[gi], force_stb[gi], tick && at_top,
                  nonpwm, dual, up_r, mode[3] && gi == 0);
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence cnt_written;
      wr_cnt;
   endsequence

   sequence lo_then_hi;
      (rd_lo && idx == 2'd0) ##1 (rd_stb && wide && addr[0]);
   endsequence

   force_no_flag_a: assert property (
      (force_stb[0] && !hit[0] && !flg_r[1]) |=> !flg_r[1])
      else $error("Forced strobe set the match flag.");

   match_flag_a: assert property (
      hit != 2'b00 |=> (flg_r[2:1] & $past(hit)) == $past(hit))
      else $error("A compare match did not set its flag.");

   cnt_block_a: assert property (
      cnt_written ##1 tick |-> hit == 2'b00)
      else $error("Match not blocked after counter write.");

   capt_load_a: assert property (
      cap_evt |=> icr_r == $past(cnt_r) && flg_r[3])
      else $error("Capture did not load counter and flag.");

   icr_top_a: assert property (
      (icr_top && !(tick && at_top) && !flg_r[3]) |=> !flg_r[3])
      else $error("Capture flag set by pin while capture is top.");

   stop_hold_a: assert property (
      (cs_r == 3'h0 && !wr_cnt) |=> $stable(cnt_r))
      else $error("Counter moved with clock stopped.");

   div8_tap_a: assert property (
      (tick && cs_r == 3'h2) |-> pre_r[2:0] == 3'h7)
      else $error("Divide-by-8 tick off its tap.");

   ext_edge_a: assert property (
      (cs_r == 3'h7 && ext_r && !ext_q_r) |-> tick)
      else $error("External rising edge gave no tick.");

   foc_read_a: assert property (
      (rd_stb && addr == `T16CC_CTRL_C) |=> rdata == 8'h00)
      else $error("Force register read non-zero.");

   flag_clr_a: assert property (
      (wr_f && wdata[`T16CC_MA_BIT] && !hit[0]) |=> !flg_r[1])
      else $error("Writing one did not clear match A flag.");

   wide_pair_a: assert property (
      lo_then_hi |=> rdata == $past(cnt_r[15:8], 2))
      else $error("High byte not paired with low byte read.");

   ovf_normal_a: assert property (
      (tick && mode == 4'h0 && cnt_r == 16'hffff && !wr_cnt)
      |=> flg_r[0] && cnt_r == 16'h0000)
      else $error("Normal mode overflow missed.");

endmodule : t16cc_timer

//--- shared/t16cc_defs.svh
`ifndef T16CC_DEFS_SVH
`define T16CC_DEFS_SVH

// Register offsets on the 8-bit register port.
`define T16CC_CTRL_A    8'h22
`define T16CC_CTRL_B    8'h23
`define T16CC_CTRL_C    8'h24
`define T16CC_FLAGS     8'h25
`define T16CC_MASK      8'h26
// Wide pairs at 0x28..0x2f: low byte even, high byte odd.
`define T16CC_WIDE_BASE 8'h28

// Field positions.
`define T16CC_NF_BIT    7
`define T16CC_CES_BIT   6
`define T16CC_FOCA_BIT  7
`define T16CC_FOCB_BIT  6
`define T16CC_CAP_BIT   7
`define T16CC_MB_BIT    5
`define T16CC_MA_BIT    4
`define T16CC_OV_BIT    3

// Reset values.
`define T16CC_RST8      8'h00
`define T16CC_RST16     16'h0000

// Timing counts and prescaler tap masks.
`define T16CC_FILT_LEN  4
`define T16CC_M8        10'h007
`define T16CC_M64       10'h03f
`define T16CC_M256      10'h0ff
`define T16CC_M1024     10'h3ff

// Fixed top values.
`define T16CC_TOP8      16'h00ff
`define T16CC_TOP9      16'h01ff
`define T16CC_TOP10     16'h03ff
`define T16CC_MAX       16'hffff

`endif

//--- shared/t16cc_pkg.sv
package t16cc_pkg;

   // Clock source selection codes.
   typedef enum logic [2:0] {
      CLK_STOP     = 3'h0,
      CLK_DIV1     = 3'h1,
      CLK_DIV8     = 3'h2,
      CLK_DIV64    = 3'h3,
      CLK_DIV256   = 3'h4,
      CLK_DIV1024  = 3'h5,
      CLK_EXT_FALL = 3'h6,
      CLK_EXT_RISE = 3'h7
   } t16cc_clk_t;

   // Compare output actions.
   typedef enum logic [1:0] {
      OUT_OFF    = 2'h0,
      OUT_TOGGLE = 2'h1,
      OUT_CLEAR  = 2'h2,
      OUT_SET    = 2'h3
   } t16cc_com_t;

endpackage : t16cc_pkg

//--- hw/t16cc_capt_filter.sv
`timescale 1ns/1ns
`include "t16cc_defs.svh"

module t16cc_capt_filter #(
   parameter int LEN = `T16CC_FILT_LEN // Equal samples to switch.
) (
   input  logic clock,     // System clock.
   input  logic rst_n,     // Asynchronous reset, active low.
   input  logic raw_in,    // Selected capture source.
   input  logic filter_en, // Noise filter on.
   input  logic edge_rise, // One picks rising edges.
   input  logic enable,    // Capture allowed.
   output logic event_out  // One-cycle capture event.
);

   logic [LEN-1:0] samp_r;
   logic           filt_r;
   logic           prev_r;

   // Filter and edge selection.
   wire all_hi = &samp_r;
   wire all_lo = ~|samp_r;
   wire sel    = filter_en ? filt_r : samp_r[0];

   // Sample shifter, filtered level and edge history.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         samp_r <= '0;
         filt_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         samp_r <= {samp_r[LEN-2:0], raw_in};
         if (all_hi)
            filt_r <= 1'b1;
         else if (all_lo)
            filt_r <= 1'b0;
         prev_r <= sel;
      end
   end

   // The event marks the chosen edge of the chosen level.
   assign event_out = enable &&
      (edge_rise ? (sel && !prev_r) : (!sel && prev_r));

   // The filtered level moves only after a run of equal samples.
   filt_run_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(filt_r) |-> ($past(samp_r) == {LEN{filt_r}}))
      else $error("Filtered capture level moved without a full run.");

   // An event always lands on the level of the chosen edge.
   edge_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
      event_out |-> (sel == edge_rise) && (prev_r != edge_rise))
      else $error("Capture event on the wrong edge.");

endmodule : t16cc_capt_filter

//--- tb/t16cc_core_model.sv
`timescale 1ns/1ns

// Register-port master that stands in for the processor core.
module t16cc_core_model (
   input  logic       clock,  // System clock.
   input  logic [7:0] rdata,  // Read data from the timer.
   output logic [7:0] addr,   // Register address.
   output logic [7:0] wdata,  // Write data.
   output logic       wr_stb, // Write strobe.
   output logic       rd_stb  // Read strobe.
);
   // The bus idles with both strobes low.
   initial
   begin
      addr   = 8'h00;
      wdata  = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // One write cycle; callers pass zeros in reserved positions.
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask : wr8

   // Read data stand only in the cycle after the strobe, so take them then.
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask : rd8

   // Wide write puts the high byte in the shared latch first.
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr8(a + 8'h01, d[15:8]);
      wr8(a, d[7:0]);
   endtask : wr16

   // Wide read takes the low byte first, which latches the high byte.
   // The two strobes run back to back; each byte is taken as it stands.
   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      addr   <= a + 8'h01;
      @(negedge clock);
      d[7:0] = rdata;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(negedge clock);
      d[15:8] = rdata;
   endtask : rd16
endmodule : t16cc_core_model

//--- tb/tb_timer16_capture_compare_regs.sv
`timescale 1ns/1ns

module tb_timer16_capture_compare_regs;
   logic        clock, rst_n, wr_stb, rd_stb;
   logic [7:0]  addr, wdata, rdata, b;
   logic        cap_pin, cmp_out, cap_cmp, ext_pin, gie, o;
   logic        wa, wb, wae, wbe;
   logic [3:0]  ack, irq;
   logic [15:0] v;
   int          error_cnt, total_checks, cyc;
   int          dv [6] = '{0, 1, 8, 64, 256, 1024};
   // Rows: address, write data, expected read back.
   logic [23:0] rows [8] = '{24'h22f0f0, 24'h220000, 24'h23d8d8,
      24'h230000, 24'h24c000, 24'h26b8b8, 24'h260000, 24'h305500};

   t16cc_core_model core_u (.clock(clock), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));

   t16cc_timer dut_u (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .capture_input_pin(cap_pin), .comparator_out(cmp_out),
      .capture_from_comparator(cap_cmp), .external_count_pin(ext_pin),
      .global_irq_en(gie), .vector_ack(ack), .irq_req(irq),
      .waveform_out_a(wa), .waveform_out_b(wb),
      .waveform_out_a_en(wae), .waveform_out_b_en(wbe));

   // The clock toggles every half period of 20 ns.
   always #20 clock = ~clock;

   // Prints the counts and the verdict, then stops.
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // Compares one value and reports a mismatch.
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk

   // Checks a counter against a window that allows prescaler phase.
   task automatic chkr(input string n, input int lo, input int hi,
                       input logic [15:0] g);
      total_checks++;
      if ((^g === 1'bx) || g < lo || g > hi)
      begin
         error_cnt++;
         $display("wrong value %s exp %0d..%0d got %h", n, lo, hi, g);
      end
   endtask : chkr

   // Reads one byte register and compares it.
   task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                      input string n);
      core_u.rd8(a, b);
      chk(n, {8'h00, e}, {8'h00, b});
   endtask : rdc

   // Waits a number of clock edges.
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // Counts clock cycles and cuts a hang short.
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      {cap_pin, cmp_out, cap_cmp, ext_pin, gie} = 5'h00;
      ack = 4'h0;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      tick(20);
      rst_n <= 1'b1;
      // Ordinary register accesses from the row table.
      for (int i = 0; i < 8; i++)
      begin
         core_u.wr8(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0], "reg");
      end
      $display("test rows done");
      // A reset in mid-run returns every register to zero.
      core_u.wr8(8'h26, 8'hb8);
      core_u.wr16(8'h2a, 16'h1234);
      @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 8'h22; a < 8'h30; a++)
         rdc(8'(a), 8'h00, "reset");
      chk("irq", 16'h0000, {12'h000, irq});
      $display("test reset done");
      // All wide registers share one high-byte latch.
      core_u.wr16(8'h2a, 16'h1234);
      core_u.rd16(8'h2a, v);
      chk("cmp_a", 16'h1234, v);
      core_u.wr8(8'h2d, 8'hab);
      core_u.wr8(8'h2a, 8'h56);
      core_u.rd16(8'h2a, v);
      chk("latch", 16'hab56, v);
      core_u.wr16(8'h2c, 16'h8000);
      $display("test latch done");
      // Every internal clock select, stopped included.
      for (int i = 0; i < 6; i++)
      begin
         core_u.wr16(8'h28, 16'h0000);
         core_u.wr8(8'h23, 8'(i));
         tick(2048);
         core_u.wr8(8'h23, 8'h00);
         core_u.rd16(8'h28, v);
         if (i == 0)
            chk("stop", 16'h0000, v);
         else
            chkr("div", 2048 / dv[i] - 1, 2048 / dv[i] + 3, v);
      end
      // Both external pin edges give one count per pulse.
      for (int i = 6; i < 8; i++)
      begin
         core_u.wr16(8'h28, 16'h0000);
         core_u.wr8(8'h23, 8'(i));
         repeat (5)
         begin
            tick(4);
            ext_pin <= 1'b1;
            tick(4);
            ext_pin <= 0;
         end
         tick(4);
         core_u.wr8(8'h23, 8'h00);
         core_u.rd16(8'h28, v);
         chk("ext", 16'h0005, v);
      end
      $display("test clock done");
      // Forced match under each output mode, in clear-on-match mode.
      core_u.wr8(8'h23, 8'h08);
      for (int c = 0; c < 4; c++)
      begin
         o = (c == 0) ? wa : (c == 1) ? ~wa : (c == 3);
         core_u.wr8(8'h22, 8'(c << 6));
         core_u.wr8(8'h24, 8'h80);
         tick(2);
         @(negedge clock);
         chk("out_a", {15'h0, o}, {15'h0, wa});
         chk("en_a", {15'h0, c != 0}, {15'h0, wae});
      end
      core_u.wr8(8'h22, 8'h30);
      core_u.wr8(8'h24, 8'h40);
      tick(2);
      @(negedge clock);
      chk("out_b", 16'h0003, {14'h0, wb, wbe});
      rdc(8'h25, 8'h00, "force flag");
      core_u.rd16(8'h28, v);
      chk("force clr", 16'h0005, v);
      core_u.wr8(8'h22, 8'h00);
      core_u.wr8(8'h23, 8'h00);
      $display("test force done");
      // Match and overflow set flags that request enabled interrupts.
      core_u.wr8(8'h26, 8'h18);
      gie <= 1'b1;
      core_u.wr16(8'h2a, 16'hfffc);
      core_u.wr16(8'h28, 16'hfffa);
      core_u.wr8(8'h23, 8'h01);
      tick(20);
      core_u.wr8(8'h23, 8'h00);
      rdc(8'h25, 8'h18, "flags");
      chk("irq", 16'h0003, {12'h000, irq});
      @(posedge clock);
      gie <= 1'b0;
      ack <= 4'h1;
      @(posedge clock);
      ack <= 4'h0;
      @(negedge clock);
      chk("irq off", 16'h0000, {12'h000, irq});
      rdc(8'h25, 8'h10, "ack");
      core_u.wr8(8'h25, 8'h10);
      rdc(8'h25, 8'h00, "w1c");
      // A counter write suppresses the match on the next tick.
      core_u.wr16(8'h2a, 16'h0100);
      core_u.wr8(8'h23, 8'h01);
      core_u.wr16(8'h28, 16'h0100);
      tick(4);
      core_u.wr8(8'h23, 8'h00);
      rdc(8'h25, 8'h00, "blocked");
      $display("test flags done");
      // Capture on the selected edge copies the stopped counter.
      core_u.wr16(8'h28, 16'h0abc);
      core_u.wr8(8'h23, 8'h40);
      @(posedge clock);
      cap_pin <= 1'b1;
      tick(6);
      core_u.rd16(8'h2e, v);
      chk("cap rise", 16'h0abc, v);
      rdc(8'h25, 8'h80, "cap flag");
      core_u.wr8(8'h25, 8'h80);
      core_u.wr16(8'h28, 16'h0def);
      cap_pin <= 1'b0;
      tick(6);
      core_u.rd16(8'h2e, v);
      chk("no fall", 16'h0abc, v);
      core_u.wr8(8'h23, 8'h00);
      cap_pin <= 1'b1;
      tick(6);
      core_u.wr16(8'h28, 16'h0123);
      cap_pin <= 1'b0;
      tick(6);
      core_u.rd16(8'h2e, v);
      chk("cap fall", 16'h0123, v);
      // The filter ignores a three-sample pulse and passes a long one.
      core_u.wr8(8'h23, 8'hc0);
      tick(8);
      core_u.wr8(8'h25, 8'h80);
      cap_pin <= 1'b1;
      tick(3);
      cap_pin <= 1'b0;
      tick(8);
      rdc(8'h25, 8'h00, "filt short");
      core_u.wr16(8'h28, 16'h0789);
      cap_pin <= 1'b1;
      tick(10);
      core_u.rd16(8'h2e, v);
      chk("filt long", 16'h0789, v);
      // The comparator can be picked as capture source.
      core_u.wr8(8'h23, 8'h40);
      cap_cmp <= 1'b1;
      core_u.wr16(8'h28, 16'h0aaa);
      core_u.wr8(8'h25, 8'h80);
      cmp_out <= 1'b1;
      tick(6);
      core_u.rd16(8'h2e, v);
      chk("cap cmp", 16'h0aaa, v);
      @(posedge clock);
      {cap_pin, cmp_out, cap_cmp} <= 3'h0;
      $display("test capture done");
      // With the capture register as top, the pin is ignored.
      core_u.wr16(8'h2e, 16'h0040);
      core_u.wr16(8'h28, 16'h0000);
      core_u.wr8(8'h23, 8'h58);
      core_u.wr8(8'h25, 8'h80);
      cap_pin <= 1'b1;
      tick(6);
      rdc(8'h25, 8'h00, "pin off");
      core_u.wr8(8'h23, 8'h59);
      tick(80);
      core_u.wr8(8'h23, 8'h58);
      rdc(8'h25, 8'h80, "cap top");
      $display("test top done");
      print_verdict();
   end
endmodule : tb_timer16_capture_compare_regs
